// >>> design/ipr_prio_reg.v
// interrupt priority control register 1 behind an axi4-lite slave
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_prio_reg (
    aclk,
    aresetn,
    ce,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    src_level,
    src_enable
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire        ce;
    input  wire [3:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output reg         s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output reg         s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [3:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output reg         s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    output wire [11:0] src_level;   // tmr2 11:9 .. dma0 2:0 packed as 3 bits each
    output wire [3:0]  src_enable;  // bit0 dma0, 1 cap2, 2 cmp2, 3 tmr2

    reg  [15:0] prio1_r;
    reg  [3:0]  aw_addr_r;
    reg         aw_held_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_held_r;
    reg  [15:0] wr_merge;
    wire        aw_take;
    wire        w_take;
    wire        do_write;
    wire [3:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire [11:0] lvl_w;
    wire [3:0]  en_w;
    reg  [31:0] rd_val;
    reg  [1:0]  rd_resp;
    wire [1:0]  wr_idx;
    wire        wr_hit_prio;
    wire        wr_hit_ro;
    wire [1:0]  rd_idx;
    wire [15:0] wr_lane_mask;
    wire [11:0] fld_pack;
    wire [2:0]  timer2_priority_field;
    wire [2:0]  compare2_priority_field;
    wire [2:0]  capture2_priority_field;
    wire [2:0]  dma0_done_priority_field;

    // word indices: the slave decodes address bits 3:2 only, so aliases repeat
    localparam [3:0]  OFF_PRIO1   = `IPR_OFF_PRIO1;
    localparam [3:0]  OFF_LEVEL   = `IPR_OFF_LEVEL;
    localparam [3:0]  OFF_ENABLE  = `IPR_OFF_ENABLE;
    localparam [1:0]  IDX_PRIO1   = OFF_PRIO1[3:2];
    localparam [1:0]  IDX_LEVEL   = OFF_LEVEL[3:2];
    localparam [1:0]  IDX_ENABLE  = OFF_ENABLE[3:2];
    localparam [15:0] PRIO1_WMASK = `IPR_PRIO1_WMASK;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    // address and data may arrive in either order; either may be held
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    assign do_write = (aw_held_r | aw_take) & (w_held_r | w_take) & ~s_axi_bvalid;

    // write decode: the priority word is stored, the two readback words drop writes
    assign wr_idx      = wr_addr[3:2];
    assign wr_hit_prio = (wr_idx == IDX_PRIO1);
    assign wr_hit_ro   = (wr_idx == IDX_LEVEL) || (wr_idx == IDX_ENABLE);
    assign rd_idx      = s_axi_araddr[3:2];

    // one mask byte per strobed lane; the upper lanes have nothing behind them
    genvar li;
    generate
        for (li = 0; li < 2; li = li + 1) begin : g_lane
            assign wr_lane_mask[8*li +: 8] = {8{wr_strb[li]}};
        end
    endgenerate

    // byte-lane merge; unimplemented bits masked so writes there are lost
    always @* begin
        wr_merge = (wr_data[15:0] & wr_lane_mask) | (prio1_r & ~wr_lane_mask);
        wr_merge = wr_merge & PRIO1_WMASK;
    end

    // write channels: accept each once, answer after both are in
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IPR_RESP_OKAY;
            prio1_r       <= `IPR_PRIO1_RESET;
        end else if (ce) begin
            if (do_write) begin
                aw_held_r     <= 1'b0;
                w_held_r      <= 1'b0;
                s_axi_awready <= 1'b0;   // stall until response is taken
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                if (wr_hit_prio) begin
                    prio1_r     <= wr_merge;
                    s_axi_bresp <= `IPR_RESP_OKAY;
                end else if (wr_hit_ro) begin
                    s_axi_bresp <= `IPR_RESP_OKAY;   // read-only status, write dropped
                end else begin
                    s_axi_bresp <= `IPR_RESP_SLVERR;
                end
            end else begin
                if (aw_take) begin
                    aw_held_r     <= 1'b1;
                    aw_addr_r     <= s_axi_awaddr;
                    s_axi_awready <= 1'b0;
                end
                if (w_take) begin
                    w_held_r     <= 1'b1;
                    w_data_r     <= s_axi_wdata;
                    w_strb_r     <= s_axi_wstrb;
                    s_axi_wready <= 1'b0;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid  <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready  <= 1'b1;
                end
            end
        end
    end

    // named views of the four fields, packed lowest source first for the decoders
    assign timer2_priority_field    = prio1_r[`IPR_FLD_TMR2_LSB +: `IPR_FLD_W];
    assign compare2_priority_field  = prio1_r[`IPR_FLD_CMP2_LSB +: `IPR_FLD_W];
    assign capture2_priority_field  = prio1_r[`IPR_FLD_CAP2_LSB +: `IPR_FLD_W];
    assign dma0_done_priority_field = prio1_r[`IPR_FLD_DMA0_LSB +: `IPR_FLD_W];
    assign fld_pack = {timer2_priority_field, compare2_priority_field,
                       capture2_priority_field, dma0_done_priority_field};

    // per-source decoders; same encoding for all four fields
    genvar gi;
    generate
        for (gi = 0; gi < `IPR_NUM_SRC; gi = gi + 1) begin : g_src
            ipr_level_decode u_dec (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .field   (fld_pack[3*gi +: `IPR_FLD_W]),
                .level   (lvl_w[3*gi +: 3]),
                .enabled (en_w[gi])
            );
        end
    endgenerate
    assign src_level  = lvl_w;
    assign src_enable = en_w;

    // read mux; reserved bits of the register come back as zero
    always @* begin
        rd_val  = 32'h0;
        rd_resp = `IPR_RESP_OKAY;
        case (rd_idx)
            IDX_PRIO1: rd_val = {16'h0, prio1_r & PRIO1_WMASK};
            IDX_LEVEL: rd_val = {20'h0, lvl_w};
            IDX_ENABLE: rd_val = {28'h0, en_w};
            default: rd_resp = `IPR_RESP_SLVERR;
        endcase
    end

    // read channel: one read at a time, data held until rready
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `IPR_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // ipr_prio_reg

// >>> include/ipr_map.vh
// register map, field positions and reset values of the priority register block
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

`define IPR_OFF_PRIO1        4'h0
`define IPR_OFF_LEVEL        4'h4
`define IPR_OFF_ENABLE       4'h8
`define IPR_PRIO1_RESET      16'h4444
`define IPR_PRIO1_WMASK      16'h7777
`define IPR_FLD_DMA0_LSB     0
`define IPR_FLD_CAP2_LSB     4
`define IPR_FLD_CMP2_LSB     8
`define IPR_FLD_TMR2_LSB     12
`define IPR_FLD_W            3
`define IPR_CODE_OFF         3'h0
`define IPR_NUM_SRC          4
`define IPR_RESP_OKAY        2'h0
`define IPR_RESP_SLVERR      2'h2

`endif

// >>> design/ipr_level_decode.v
// decodes one priority field into a level and an enable, registered
`timescale 1ns/1ps
module ipr_level_decode (
    aclk,
    aresetn,
    ce,
    field,
    level,
    enabled
);
    input  wire       aclk;
    input  wire       aresetn;
    input  wire       ce;
    input  wire [2:0] field;
    output reg  [2:0] level;
    output reg        enabled;

    // codes map straight to levels 1..7 in binary order; 000 disables
    always @(posedge aclk) begin
        if (!aresetn) begin
            level   <= 3'h0;
            enabled <= 1'b0;
        end else if (ce) begin
            level   <= field;
            enabled <= (field != `IPR_CODE_OFF);
        end
    end
endmodule // ipr_level_decode

// >>> test/ipr_prio_reg_checker.sv
// port assertions for the priority register slave
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_prio_reg_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire [3:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [11:0] src_level,
    input wire [3:0]  src_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [3:0] ra_r;
    // remember the read offset so the answer can be judged by its source
    always @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_of(logic [3:0] a);
        s_axi_rvalid && ra_r == a;
    endsequence
    a_rd_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
    a_rsv_zero: assert property (rd_of(4'h0) |-> (s_axi_rdata & 32'hFFFF8888) == 32'h0)
        else $error("reserved bits read nonzero");
    a_bad_addr: assert property (rd_of(4'hC) |-> s_axi_rresp == `IPR_RESP_SLVERR)
        else $error("unmapped read not refused");
    // a read taken at word index idx; data and decoder outputs load on the same edge
    sequence rd_take_at(logic [1:0] idx);
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == idx;
    endsequence
    a_lvl_read: assert property (rd_take_at(2'h1) |=> s_axi_rdata[11:0] == $past(src_level))
        else $error("level readback differs from port");
    a_en_read: assert property (rd_take_at(2'h2) |=> s_axi_rdata[3:0] == $past(src_enable))
        else $error("enable readback differs from port");
    a_off_code: assert property (rd_take_at(2'h0) |=> (s_axi_rdata[10:8] == 3'h0) == !src_enable[2])
        else $error("disabled code and enable disagree");
    a_on_level: assert property (rd_take_at(2'h0) |=>
        src_level == {s_axi_rdata[14:12], s_axi_rdata[10:8], s_axi_rdata[6:4], s_axi_rdata[2:0]})
        else $error("field code and level disagree");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule // ipr_prio_reg_checker
bind ipr_prio_reg ipr_prio_reg_checker u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .src_level, .src_enable);

// >>> test/ipr_prio_reg_bench.sv
// self-checking bench for the priority register over axi4-lite
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_prio_reg_bench;
    logic        aclk, aresetn = 0, s_axi_awready, s_axi_wready, s_axi_arready;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_bvalid;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0, src_enable;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] src_level;
    logic        ce = 1'b1;
    int          fails = 0, checks = 0, c;
    ipr_prio_reg dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_level, .src_enable);
    // 50 ns clock
    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    task finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // a used-up wait counts as a mismatch and ends the run
    task lim(input int n);
        if (n >= 50) begin
            fails++;
            finish_test();
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input [3:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        lim(n);
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input [3:0] a, input [31:0] e, input [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        lim(n);
        chk("rresp", er, s_axi_rresp);
        if (er == `IPR_RESP_OKAY) chk("rdata", e, s_axi_rdata);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IPR_OFF_PRIO1, `IPR_PRIO1_RESET, 0);
        chk("src_level", 12'h924, src_level);
        chk("src_enable", 4'hF, src_enable);
        // every code in all four fields, reserved bits written as ones
        for (c = 0; c < 8; c++) begin
            wr(0, {4{1'b1, c[2:0]}}, 4'h3, 0);
            rd(0, {4{1'b0, c[2:0]}}, 0);
            rd(`IPR_OFF_LEVEL, {4{c[2:0]}}, 0);
            rd(`IPR_OFF_ENABLE, {4{c != 0}}, 0);
            chk("src_enable", {4{c != 0}}, src_enable);
            chk("cmp2_level", c, src_level[8:6]);
        end
        $display("test codes done");
        wr(0, 32'hF9D8, 4'h3, 0);
        rd(0, 32'h7150, 0);
        rd(`IPR_OFF_LEVEL, {3'h7, 3'h1, 3'h5, 3'h0}, 0);
        wr(0, 32'hFF33, 4'h1, 0);
        rd(0, 32'h7133, 0);
        $display("test fields done");
        wr(`IPR_OFF_LEVEL, 32'h0, 4'hF, `IPR_RESP_OKAY);
        wr(4'hC, 32'h0, 4'hF, `IPR_RESP_SLVERR);
        rd(4'hC, 32'h0, `IPR_RESP_SLVERR);
        rd(0, 32'h7133, 0);
        $display("test errors done");
        // reset in mid-run puts every field back to level 4
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(0, `IPR_PRIO1_RESET, 0);
        chk("src_level", 12'h924, src_level);
        chk("src_enable", 4'hF, src_enable);
        $display("test reset done");
        // a write offered while the clock enable is low is lost and never answered
        @(posedge aclk);
        ce <= 1'b0;
        s_axi_awaddr <= `IPR_OFF_PRIO1;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(posedge aclk);
        chk("frozen_bvalid", 0, s_axi_bvalid);
        ce <= 1'b1;
        rd(0, `IPR_PRIO1_RESET, 0);
        chk("frozen_level", 12'h924, src_level);
        $display("test freeze done");
        finish_test();
    end
endmodule // ipr_prio_reg_bench
